// ==== rtl/mdio_pkg.sv ====
// Shared constants and types for the management slave
package mdio_pkg;
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam logic [5:0] PRE_LEN = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0c;
  localparam logic [5:0] DATA_LAST = 6'h0f;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [4:0] PHY_ADDR0_DEF = 5'h00;
  localparam logic [4:0] PHY_ADDR1_DEF = 5'h01;
  localparam logic [4:0] TARGET_ADDR_LOW = 5'h00;
  localparam logic [4:0] TARGET_ADDR_HIGH = 5'h01;
  localparam logic [4:0] XFER_DATA_LOW = 5'h02;
  localparam logic [4:0] XFER_DATA_HIGH_TRIGGER = 5'h03;
  localparam logic [4:0] XFER_DATA_HIGH_AUTOINC = 5'h04;
  localparam logic [4:0] XFER_DATA_HIGH_PASSIVE = 5'h05;
  localparam logic [4:0] ACCESS_STATUS = 5'h06;
  localparam logic [15:0] SENT16 = 16'h8888;
  localparam logic [31:0] SENT32 = 32'h88888888;
  localparam logic [31:0] WORD_ONE = 32'h00000001;
  localparam logic [31:0] SB_ADDR_STEP = 32'h00000004;
  localparam logic [31:0] SB_WIN_BASE = 32'h00000100;
  localparam logic [2:0] SB_CTRL_IDX = 3'h0;
  localparam logic [2:0] SB_ADDR_IDX = 3'h1;
  localparam logic [2:0] SB_DATA_IDX = 3'h2;
  localparam logic [2:0] SB_INC_IDX = 3'h3;
  localparam logic [2:0] SB_PAS_IDX = 3'h4;
  localparam int SB_BUSY_BIT = 0;
  localparam int SB_ERR_BIT = 1;
  typedef enum logic [2:0] {
    ST_PRE = 3'b000,
    ST_HDR = 3'b001,
    ST_TA = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100
  } frame_state_type;
endpackage

// ==== rtl/sb_regs_if.sv ====
// Register access path from the slave engine to the shared-bus access block
`timescale 1ns/1ns
`default_nettype none
interface sb_regs_if;
  logic req;
  logic write;
  logic [2:0] idx;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ack;
  modport host (output req, write, idx, wdata, input rdata, ack);
  modport target (input req, write, idx, wdata, output rdata, ack);
endinterface
`default_nettype wire

// ==== rtl/shared_bus_access.sv ====
// Indirect 32-bit access block for the internal shared bus
`timescale 1ns/1ns
`default_nettype none
module shared_bus_access (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Register side
  sb_regs_if.target regs,
  // Shared bus master
  output logic sbReq,
  output logic sbWrite,
  output logic [mdio_pkg::WORD_W-1:0] sbAddr,
  output logic [mdio_pkg::WORD_W-1:0] sbWdata,
  input wire logic sbAck,
  input wire logic sbErr,
  input wire logic [mdio_pkg::WORD_W-1:0] sbRdata
);
  import mdio_pkg::*;
  logic busy_r, busy_nxt;
  logic err_r, err_nxt;
  logic wr_r, wr_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [31:0] data_r, data_nxt;
  logic [31:0] outAddr_r, outAddr_nxt;
  logic [31:0] outData_r, outData_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic acc;

  always_comb begin
    acc = regs.req & ~ack_r;
    busy_nxt = busy_r;
    err_nxt = err_r;
    wr_nxt = wr_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    outAddr_nxt = outAddr_r;
    outData_nxt = outData_r;
    rdata_nxt = rdata_r;
    ack_nxt = acc;
    if (acc) begin
      case (regs.idx)
        SB_CTRL_IDX: begin
          rdata_nxt = '0;
          rdata_nxt[SB_BUSY_BIT] = busy_r;
          rdata_nxt[SB_ERR_BIT] = err_r;
          if (regs.write && regs.wdata[SB_ERR_BIT]) err_nxt = 1'b0;
        end
        SB_ADDR_IDX: begin
          rdata_nxt = addr_r;
          if (regs.write) addr_nxt = regs.wdata;
        end
        SB_DATA_IDX, SB_INC_IDX: begin
          rdata_nxt = busy_r ? SENT32 : data_r;
          if (!busy_r) begin
            busy_nxt = 1'b1;
            wr_nxt = regs.write;
            outAddr_nxt = addr_r;
            outData_nxt = regs.write ? regs.wdata : data_r;
            if (regs.write) data_nxt = regs.wdata;
            if (regs.idx == SB_INC_IDX) addr_nxt = addr_r + SB_ADDR_STEP;
          end
        end
        SB_PAS_IDX: begin
          rdata_nxt = busy_r ? SENT32 : data_r;
          if (regs.write) data_nxt = regs.wdata;
        end
        default: rdata_nxt = '0;
      endcase
    end
    if (busy_r && (sbAck || sbErr)) begin
      busy_nxt = 1'b0;
      if (sbErr) begin
        err_nxt = 1'b1;
        data_nxt = SENT32;
      end else if (!wr_r) begin
        data_nxt = sbRdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      err_r <= 1'b0;
      wr_r <= 1'b0;
      ack_r <= 1'b0;
      addr_r <= '0;
      data_r <= '0;
      outAddr_r <= '0;
      outData_r <= '0;
      rdata_r <= '0;
    end else if (clkEn) begin
      busy_r <= busy_nxt;
      err_r <= err_nxt;
      wr_r <= wr_nxt;
      ack_r <= ack_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      outAddr_r <= outAddr_nxt;
      outData_r <= outData_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign sbReq = busy_r;
  assign sbWrite = wr_r;
  assign sbAddr = outAddr_r;
  assign sbWdata = outData_r;
  assign regs.ack = ack_r;
  assign regs.rdata = rdata_r;

  property p_sb_err;
    @(posedge clk) disable iff (!rst_n)
    clkEn && busy_r && sbErr |=> err_r && data_r == SENT32 && !busy_r;
  endproperty
  a_sb_err: assert property (p_sb_err) else $error("shared bus error not recorded");
  property p_sb_inc;
    @(posedge clk) disable iff (!rst_n)
    clkEn && acc && regs.idx == SB_INC_IDX && !busy_r |=> addr_r == $past(addr_r) + SB_ADDR_STEP;
  endproperty
  a_sb_inc: assert property (p_sb_inc) else $error("autoinc address did not step by four");
  property p_sb_busy_read;
    @(posedge clk) disable iff (!rst_n)
    clkEn && acc && !regs.write && busy_r
      && (regs.idx == SB_DATA_IDX || regs.idx == SB_INC_IDX || regs.idx == SB_PAS_IDX) |=> regs.rdata == SENT32;
  endproperty
  a_sb_busy_read: assert property (p_sb_busy_read) else $error("busy read lacks sentinel");
  c_sb_err: cover property (@(posedge clk) disable iff (!rst_n) busy_r && sbErr);
endmodule
`default_nettype wire

// ==== rtl/mdio_slave_indirect_access.sv ====
// Management serial slave with indirect 32-bit register and shared-bus access
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Data line sampled and changed on clock rise
// - Frames follow standard clause 22 format
// - Answer only the selected PHY address
// - Seven 16-bit registers, address 6 status
// - Address halves form the target word address
// - Data low reads 0x8888 after read error
// - Write of trigger or autoinc data high starts internal write
// - Internal read starts after trigger or autoinc data high read
// - Autoinc register also bumps address after access
// - Passive data high starts no access
// - Status shows busy, last busy, error
// - Trigger registers read 0x8888 when busy/read error
// - Shared data write starts bus write
// - Shared data read starts bus read, stores
// - Autoinc alias adds four to address
// - Passive alias never starts bus access
// - Bus error sets flag, data 0x88888888
// - Busy data-alias reads return 0x88888888
// - Sequential address advances only when not busy
module mdio_slave_indirect_access #(
  parameter logic [4:0] PHY_ADDR0 = mdio_pkg::PHY_ADDR0_DEF,
  parameter logic [4:0] PHY_ADDR1 = mdio_pkg::PHY_ADDR1_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Management link pins
  input wire logic slaveMgmtClockPin,
  input wire logic slaveMgmtDataPinIn,
  output logic slaveMgmtDataPinOut,
  output logic slaveMgmtDataPinOe,
  // Configuration
  input wire logic phyAddressSelect,
  // Internal register bus
  output logic regReq,
  output logic regWrite,
  output logic [mdio_pkg::WORD_W-1:0] regAddr,
  output logic [mdio_pkg::WORD_W-1:0] regWdata,
  input wire logic regAck,
  input wire logic regErr,
  input wire logic [mdio_pkg::WORD_W-1:0] regRdata,
  // Shared bus
  output logic sbReq,
  output logic sbWrite,
  output logic [mdio_pkg::WORD_W-1:0] sbAddr,
  output logic [mdio_pkg::WORD_W-1:0] sbWdata,
  input wire logic sbAck,
  input wire logic sbErr,
  input wire logic [mdio_pkg::WORD_W-1:0] sbRdata
);
  import mdio_pkg::*;
  sb_regs_if sbRegs();

  shared_bus_access u_sba (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .regs(sbRegs.target),
    .sbReq(sbReq),
    .sbWrite(sbWrite),
    .sbAddr(sbAddr),
    .sbWdata(sbWdata),
    .sbAck(sbAck),
    .sbErr(sbErr),
    .sbRdata(sbRdata)
  );

  logic [2:0] clkSync_r, clkSync_nxt;
  logic [2:0] dataSync_r, dataSync_nxt;
  logic clkLvl_r, clkLvl_nxt;
  frame_state_type fstate_r, fstate_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic opRead_r, opRead_nxt;
  logic [4:0] regSel_r, regSel_nxt;
  logic out_r, out_nxt;
  logic oe_r, oe_nxt;
  logic [15:0] addrLo_r, addrLo_nxt;
  logic [15:0] addrHi_r, addrHi_nxt;
  logic [15:0] dataLo_r, dataLo_nxt;
  logic [15:0] dataHi_r, dataHi_nxt;
  logic busy_r, busy_nxt;
  logic busyRd_r, busyRd_nxt;
  logic err_r, err_nxt;
  logic rdErr_r, rdErr_nxt;
  logic incPend_r, incPend_nxt;
  logic selSb_r, selSb_nxt;
  logic opWr_r, opWr_nxt;
  logic regReq_r, regReq_nxt;
  logic sbReqI_r, sbReqI_nxt;
  logic rise, bitIn, phyHit, hdrOk, done, trig, startRd, startWr;
  logic [12:0] hdr;
  logic [15:0] rdVal;
  logic [31:0] tgt, doneData;

  always_comb begin
    clkSync_nxt = {clkSync_r[1:0], slaveMgmtClockPin};
    dataSync_nxt = {dataSync_r[1:0], slaveMgmtDataPinIn};
    // Level accepted once second and third stages agree
    clkLvl_nxt = (clkSync_r[1] == clkSync_r[2]) ? clkSync_r[2] : clkLvl_r;
    rise = clkSync_r[1] & clkSync_r[2] & ~clkLvl_r;
    bitIn = dataSync_r[2];
    hdr = {shift_r[11:0], bitIn};
    phyHit = hdr[9:5] == (phyAddressSelect ? PHY_ADDR1 : PHY_ADDR0);
    hdrOk = hdr[12] & phyHit & (hdr[4:0] <= ACCESS_STATUS)
      & ((hdr[11:10] == OP_READ) | (hdr[11:10] == OP_WRITE));
    tgt = {addrHi_r, addrLo_r};
    trig = (regSel_r == XFER_DATA_HIGH_TRIGGER) | (regSel_r == XFER_DATA_HIGH_AUTOINC);
    done = busy_r & (selSb_r ? sbRegs.ack : (regAck | regErr));
    doneData = selSb_r ? sbRegs.rdata : regRdata;
    case (hdr[4:0])
      TARGET_ADDR_LOW: rdVal = addrLo_r;
      TARGET_ADDR_HIGH: rdVal = addrHi_r;
      XFER_DATA_LOW: rdVal = rdErr_r ? SENT16 : dataLo_r;
      XFER_DATA_HIGH_TRIGGER, XFER_DATA_HIGH_AUTOINC: rdVal = (busy_r | rdErr_r) ? SENT16 : dataHi_r;
      XFER_DATA_HIGH_PASSIVE: rdVal = rdErr_r ? SENT16 : dataHi_r;
      ACCESS_STATUS: rdVal = {13'h0000, err_r, busyRd_r, busy_r};
      default: rdVal = '0;
    endcase
    startRd = 1'b0;
    startWr = 1'b0;
    fstate_nxt = fstate_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    opRead_nxt = opRead_r;
    regSel_nxt = regSel_r;
    out_nxt = out_r;
    oe_nxt = oe_r;
    addrLo_nxt = addrLo_r;
    addrHi_nxt = addrHi_r;
    dataLo_nxt = dataLo_r;
    dataHi_nxt = dataHi_r;
    busy_nxt = busy_r;
    busyRd_nxt = busyRd_r;
    err_nxt = err_r;
    rdErr_nxt = rdErr_r;
    incPend_nxt = incPend_r;
    selSb_nxt = selSb_r;
    opWr_nxt = opWr_r;
    regReq_nxt = regReq_r;
    sbReqI_nxt = sbReqI_r;
    if (rise) begin
      case (fstate_r)
        ST_PRE: begin
          if (bitIn) begin
            cnt_nxt = (cnt_r == PRE_LEN) ? cnt_r : cnt_r + 6'h01;
          end else begin
            if (cnt_r == PRE_LEN) fstate_nxt = ST_HDR;
            cnt_nxt = '0;
          end
        end
        ST_HDR: begin
          shift_nxt = {shift_r[14:0], bitIn};
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_r == HDR_LAST) begin
            cnt_nxt = '0;
            regSel_nxt = hdr[4:0];
            opRead_nxt = hdr[11:10] == OP_READ;
            if (hdrOk) begin
              fstate_nxt = ST_TA;
              if (hdr[11:10] == OP_READ) shift_nxt = rdVal;
              if ((hdr[4:0] == XFER_DATA_HIGH_TRIGGER) || (hdr[4:0] == XFER_DATA_HIGH_AUTOINC))
                busyRd_nxt = busy_r;
            end else begin
              fstate_nxt = ST_PRE;
            end
          end
        end
        ST_TA: begin
          cnt_nxt = 6'h01;
          if (opRead_r) begin
            oe_nxt = 1'b1;
            out_nxt = (cnt_r == '0) ? 1'b0 : shift_r[15];
          end
          if (cnt_r != '0) begin
            cnt_nxt = '0;
            fstate_nxt = opRead_r ? ST_RDATA : ST_WDATA;
            if (opRead_r) shift_nxt = {shift_r[14:0], 1'b0};
          end
        end
        ST_RDATA: begin
          out_nxt = shift_r[15];
          shift_nxt = {shift_r[14:0], 1'b0};
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_r == DATA_LAST) begin
            oe_nxt = 1'b0;
            out_nxt = 1'b0;
            fstate_nxt = ST_PRE;
            cnt_nxt = '0;
            startRd = trig;
          end
        end
        ST_WDATA: begin
          shift_nxt = {shift_r[14:0], bitIn};
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_r == DATA_LAST) begin
            fstate_nxt = ST_PRE;
            cnt_nxt = '0;
            startWr = trig;
            case (regSel_r)
              TARGET_ADDR_LOW: addrLo_nxt = shift_nxt;
              TARGET_ADDR_HIGH: addrHi_nxt = shift_nxt;
              XFER_DATA_LOW: dataLo_nxt = shift_nxt;
              XFER_DATA_HIGH_TRIGGER, XFER_DATA_HIGH_AUTOINC, XFER_DATA_HIGH_PASSIVE: dataHi_nxt = shift_nxt;
              default: ;
            endcase
          end
        end
        default: fstate_nxt = ST_PRE;
      endcase
    end
    if (done) begin
      busy_nxt = 1'b0;
      regReq_nxt = 1'b0;
      sbReqI_nxt = 1'b0;
      err_nxt = ~selSb_r & regErr;
      if (!opWr_r) begin
        rdErr_nxt = ~selSb_r & regErr;
        if (selSb_r || !regErr) {dataHi_nxt, dataLo_nxt} = doneData;
      end
      if (incPend_r) {addrHi_nxt, addrLo_nxt} = tgt + WORD_ONE;
    end
    if ((startRd || startWr) && !busy_r) begin
      busy_nxt = 1'b1;
      opWr_nxt = startWr;
      incPend_nxt = regSel_r == XFER_DATA_HIGH_AUTOINC;
      selSb_nxt = tgt[31:3] == SB_WIN_BASE[31:3];
      regReq_nxt = tgt[31:3] != SB_WIN_BASE[31:3];
      sbReqI_nxt = tgt[31:3] == SB_WIN_BASE[31:3];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkSync_r <= '0;
      dataSync_r <= '0;
      clkLvl_r <= 1'b0;
      fstate_r <= ST_PRE;
      cnt_r <= '0;
      shift_r <= '0;
      opRead_r <= 1'b0;
      regSel_r <= '0;
      out_r <= 1'b0;
      oe_r <= 1'b0;
      addrLo_r <= '0;
      addrHi_r <= '0;
      dataLo_r <= '0;
      dataHi_r <= '0;
      busy_r <= 1'b0;
      busyRd_r <= 1'b0;
      err_r <= 1'b0;
      rdErr_r <= 1'b0;
      incPend_r <= 1'b0;
      selSb_r <= 1'b0;
      opWr_r <= 1'b0;
      regReq_r <= 1'b0;
      sbReqI_r <= 1'b0;
    end else if (clkEn) begin
      clkSync_r <= clkSync_nxt;
      dataSync_r <= dataSync_nxt;
      clkLvl_r <= clkLvl_nxt;
      fstate_r <= fstate_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      opRead_r <= opRead_nxt;
      regSel_r <= regSel_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      addrLo_r <= addrLo_nxt;
      addrHi_r <= addrHi_nxt;
      dataLo_r <= dataLo_nxt;
      dataHi_r <= dataHi_nxt;
      busy_r <= busy_nxt;
      busyRd_r <= busyRd_nxt;
      err_r <= err_nxt;
      rdErr_r <= rdErr_nxt;
      incPend_r <= incPend_nxt;
      selSb_r <= selSb_nxt;
      opWr_r <= opWr_nxt;
      regReq_r <= regReq_nxt;
      sbReqI_r <= sbReqI_nxt;
    end
  end

  assign slaveMgmtDataPinOut = out_r;
  assign slaveMgmtDataPinOe = oe_r;
  assign regReq = regReq_r;
  assign regWrite = opWr_r;
  assign regAddr = tgt;
  assign regWdata = {dataHi_r, dataLo_r};
  assign sbRegs.req = sbReqI_r;
  assign sbRegs.write = opWr_r;
  assign sbRegs.idx = addrLo_r[2:0];
  assign sbRegs.wdata = {dataHi_r, dataLo_r};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ta_zero;
    $rose(slaveMgmtDataPinOe) |-> !slaveMgmtDataPinOut;
  endproperty
  a_ta_zero: assert property (p_ta_zero) else $error("turnaround not driven low");
  property p_drive_on_rise;
    slaveMgmtDataPinOe && $changed(slaveMgmtDataPinOut) |-> $past(rise);
  endproperty
  a_drive_on_rise: assert property (p_drive_on_rise) else $error("data changed off a clock rise");
  property p_phy_miss;
    clkEn && rise && fstate_r == ST_HDR && cnt_r == HDR_LAST && !phyHit |=> fstate_r == ST_PRE && !slaveMgmtDataPinOe;
  endproperty
  a_phy_miss: assert property (p_phy_miss) else $error("answered a foreign PHY address");
  property p_status;
    clkEn && rise && fstate_r == ST_HDR && cnt_r == HDR_LAST && hdrOk && hdr[11:10] == OP_READ
      && hdr[4:0] == ACCESS_STATUS |=> shift_r == {13'h0000, $past(err_r), $past(busyRd_r), $past(busy_r)};
  endproperty
  a_status: assert property (p_status) else $error("status word wrong");
  property p_sent_busy;
    clkEn && rise && fstate_r == ST_HDR && cnt_r == HDR_LAST && hdrOk && hdr[11:10] == OP_READ
      && hdr[4:0] == XFER_DATA_HIGH_TRIGGER && busy_r |=> shift_r == SENT16;
  endproperty
  a_sent_busy: assert property (p_sent_busy) else $error("busy read lacks sentinel");
  property p_start_wr;
    clkEn && rise && fstate_r == ST_WDATA && cnt_r == DATA_LAST && regSel_r == XFER_DATA_HIGH_TRIGGER
      && !busy_r |=> busy_r && opWr_r ##1 (regReq || sbRegs.req);
  endproperty
  a_start_wr: assert property (p_start_wr) else $error("write to data high did not start access");
  property p_passive;
    clkEn && rise && fstate_r == ST_WDATA && cnt_r == DATA_LAST && regSel_r == XFER_DATA_HIGH_PASSIVE
      && !busy_r |=> !busy_r;
  endproperty
  a_passive: assert property (p_passive) else $error("passive register started access");
  property p_inc;
    clkEn && done && incPend_r |=> tgt == $past(tgt) + WORD_ONE;
  endproperty
  a_inc: assert property (p_inc) else $error("address not advanced after autoinc access");
  property p_rd_after;
    $rose(busy_r) && !opWr_r |-> $past(fstate_r) == ST_RDATA;
  endproperty
  a_rd_after: assert property (p_rd_after) else $error("internal read started early");
  c_read_frame: cover property (fstate_r == ST_RDATA && cnt_r == DATA_LAST && rise);
  c_write_trig: cover property ($rose(busy_r) && opWr_r);
endmodule
`default_nettype wire

// ==== testbench/mgmt_master_model.sv ====
// Management link master model that frames requests toward the slave
`timescale 1ns/1ns
`default_nettype none
module mgmt_master_model (
  // Link pins
  output var logic mdClk,
  output var logic mdOut,
  output var logic mdOe,
  input wire logic mdIn
);
  initial begin
    mdClk = 1'b0;
    mdOut = 1'b1;
    mdOe = 1'b0;
  end
  // One whole frame; clock stands low between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regA,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hffffffff, 2'b01, op, phy, regA, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      // Released for turnaround and data on reads
      mdOe = (op == 2'h1) || (i > 17);
      mdOut = bits[i];
      #40;
      mdClk = 1'b1;
      if (i < 16) begin
        rd[i] = mdIn;
      end
      #40;
      mdClk = 1'b0;
    end
    mdOe = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the management slave with indirect access
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import mdio_pkg::*;
  localparam logic [31:0] WORD_A = (32'hc0123458 & 32'h00ffffff) >> 2;
  localparam logic [31:0] BAD_WORD = 32'h00000bad;
  localparam logic [31:0] SB_BAD = 32'hdead0000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic phySel = 1'b0;
  logic mdClk, mdOut, mdOe, slvOut, slvOe;
  wire logic mdWire = slvOe ? slvOut : (mdOe ? mdOut : 1'b1);
  logic regReq, regWrite, sbReq, sbWrite;
  logic [31:0] regAddr, regWdata, sbAddr, sbWdata, lastRegAddr, lastRegData, lastSbAddr, lastSbData;
  logic regAck = 1'b0, regErr = 1'b0, sbAck = 1'b0, sbErr = 1'b0;
  logic [31:0] regRdata = 32'h0, sbRdata = 32'h0;
  int n_errors = 0, n_compared = 0;
  int regDelay = 2, sbDelay = 2, regCnt = 0, sbCnt = 0, nReg = 0, nSb = 0, n;
  logic [4:0] phy = 5'h00;
  logic [15:0] r16;
  logic [31:0] r32;
  always #5 clk = ~clk;
  mdio_slave_indirect_access dut (.clk(clk), .rst_n(rst_n), .clkEn(1'b1),
    .slaveMgmtClockPin(mdClk), .slaveMgmtDataPinIn(mdWire), .slaveMgmtDataPinOut(slvOut),
    .slaveMgmtDataPinOe(slvOe), .phyAddressSelect(phySel), .regReq(regReq), .regWrite(regWrite),
    .regAddr(regAddr), .regWdata(regWdata), .regAck(regAck), .regErr(regErr), .regRdata(regRdata),
    .sbReq(sbReq), .sbWrite(sbWrite), .sbAddr(sbAddr), .sbWdata(sbWdata), .sbAck(sbAck),
    .sbErr(sbErr), .sbRdata(sbRdata));
  mgmt_master_model mm (.mdClk(mdClk), .mdOut(mdOut), .mdOe(mdOe), .mdIn(mdWire));
  // Register and shared-bus responders, one completion pulse per request
  always @(negedge clk) begin
    regAck <= 1'b0;
    regErr <= 1'b0;
    sbAck <= 1'b0;
    sbErr <= 1'b0;
    if (regReq === 1'b1 && !regAck && !regErr) begin
      regCnt <= (regCnt < regDelay) ? regCnt + 1 : 0;
      if (regCnt >= regDelay) begin
        nReg <= nReg + 1;
        regAck <= (regAddr !== BAD_WORD);
        regErr <= (regAddr === BAD_WORD);
        regRdata <= ~regAddr;
        lastRegAddr <= regWrite ? regAddr : lastRegAddr;
        lastRegData <= regWrite ? regWdata : lastRegData;
      end
    end
    if (sbReq === 1'b1 && !sbAck && !sbErr) begin
      sbCnt <= (sbCnt < sbDelay) ? sbCnt + 1 : 0;
      if (sbCnt >= sbDelay) begin
        nSb <= nSb + 1;
        sbAck <= (sbAddr !== SB_BAD);
        sbErr <= (sbAddr === SB_BAD);
        sbRdata <= ~sbAddr;
        lastSbAddr <= sbAddr;
        lastSbData <= sbWrite ? sbWdata : lastSbData;
      end
    end
  end
  task automatic wrap_up;
    if (n_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic mw(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] unused;
    mm.frame(OP_WRITE, phy, ra, d, unused);
  endtask
  task automatic mr(input logic [4:0] ra, output logic [15:0] d);
    mm.frame(OP_READ, phy, ra, 16'h0000, d);
  endtask
  task automatic setAddr(input logic [31:0] a);
    mw(TARGET_ADDR_LOW, a[15:0]);
    mw(TARGET_ADDR_HIGH, a[31:16]);
  endtask
  task automatic wr32(input logic [31:0] a, input logic [31:0] d);
    setAddr(a);
    mw(XFER_DATA_LOW, d[15:0]);
    mw(XFER_DATA_HIGH_TRIGGER, d[31:16]);
  endtask
  task automatic rd32(input logic [31:0] a, output logic [31:0] d);
    logic [15:0] hi;
    setAddr(a);
    mr(XFER_DATA_HIGH_TRIGGER, hi);
    mr(XFER_DATA_LOW, d[15:0]);
    mr(XFER_DATA_HIGH_PASSIVE, d[31:16]);
  endtask
  task automatic waitIdle;
    repeat (8) @(negedge clk);
    for (int i = 0; i < 20000; i++) begin
      @(negedge clk);
      if (regReq === 1'b0 && sbReq === 1'b0) return;
    end
    chk("idle wait", 32'h0, 32'h1);
    wrap_up();
  endtask
  function automatic logic [31:0] win(input logic [2:0] idx);
    return SB_WIN_BASE | {29'h0, idx};
  endfunction
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    wr32(WORD_A, 32'hcafe1234);
    waitIdle();
    chk("write addr", WORD_A, lastRegAddr);
    chk("write data", 32'hcafe1234, lastRegData);
    n = nReg;
    mw(XFER_DATA_HIGH_PASSIVE, 16'h5a5a);
    mr(XFER_DATA_HIGH_PASSIVE, r16);
    chk("passive high", 32'h5a5a, r16);
    chk("passive no access", n, nReg);
    rd32(WORD_A, r32);
    chk("read word", ~WORD_A, r32);
    mr(XFER_DATA_HIGH_TRIGGER, r16);
    chk("previous high", {16'h0, ~WORD_A[31:16]}, r16);
    mr(XFER_DATA_HIGH_AUTOINC, r16);
    waitIdle();
    mr(TARGET_ADDR_LOW, r16);
    chk("autoinc addr", {16'h0, WORD_A[15:0] + 16'h1}, r16);
    regDelay = 1200;
    setAddr(WORD_A);
    mr(XFER_DATA_HIGH_TRIGGER, r16);
    mr(ACCESS_STATUS, r16);
    chk("status busy", 32'h1, r16);
    mr(XFER_DATA_HIGH_TRIGGER, r16);
    chk("busy sentinel", SENT16, r16);
    waitIdle();
    mr(ACCESS_STATUS, r16);
    chk("status busy_rd", 32'h2, r16);
    regDelay = 2;
    rd32(BAD_WORD, r32);
    chk("error sentinel", 32'h88888888, r32);
    mr(ACCESS_STATUS, r16);
    chk("status error", 32'h4, r16);
    mr(XFER_DATA_HIGH_TRIGGER, r16);
    chk("error high", SENT16, r16);
    rd32(WORD_A, r32);
    chk("recovered read", ~WORD_A, r32);
    phy = 5'h01;
    mw(TARGET_ADDR_LOW, 16'h7777);
    mr(TARGET_ADDR_LOW, r16);
    chk("foreign phy", 32'hffff, r16);
    phySel = 1'b1;
    mr(TARGET_ADDR_LOW, r16);
    chk("selected phy", {16'h0, WORD_A[15:0]}, r16);
    mr(5'h07, r16);
    chk("unused address", 32'hffff, r16);
    mw(ACCESS_STATUS, 16'hffff);
    mr(ACCESS_STATUS, r16);
    chk("status read-only", 32'h0, r16);
    wr32(win(SB_ADDR_IDX), 32'h00002000);
    wr32(win(SB_DATA_IDX), 32'h11112222);
    waitIdle();
    chk("sb write data", 32'h11112222, lastSbData);
    wr32(win(SB_INC_IDX), 32'h33334444);
    waitIdle();
    chk("sb inc write addr", 32'h00002000, lastSbAddr);
    rd32(win(SB_ADDR_IDX), r32);
    chk("sb addr step", 32'h00002004, r32);
    n = nSb;
    rd32(win(SB_DATA_IDX), r32);
    chk("sb data current", 32'h33334444, r32);
    waitIdle();
    rd32(win(SB_PAS_IDX), r32);
    chk("sb read result", ~32'h00002004, r32);
    chk("sb one access", n + 1, nSb);
    sbDelay = 9000;
    rd32(win(SB_INC_IDX), r32);
    rd32(win(SB_CTRL_IDX), r32);
    chk("sb busy flag", 32'h1, r32);
    rd32(win(SB_INC_IDX), r32);
    chk("sb busy sentinel", 32'h88888888, r32);
    waitIdle();
    rd32(win(SB_ADDR_IDX), r32);
    chk("sb busy no step", 32'h00002008, r32);
    rd32(win(SB_PAS_IDX), r32);
    chk("sb passive reread", ~32'h00002004, r32);
    sbDelay = 2;
    wr32(win(SB_ADDR_IDX), SB_BAD);
    wr32(win(SB_DATA_IDX), 32'h0);
    waitIdle();
    rd32(win(SB_CTRL_IDX), r32);
    chk("sb error flag", 32'h2, r32);
    rd32(win(SB_PAS_IDX), r32);
    chk("sb error data", 32'h88888888, r32);
    wrap_up();
  end
endmodule
`default_nettype wire
